// ==== include/dlsi_pkg.sv ====
package dlsi_pkg;
    // clock and controller cycle timing
    localparam int unsigned CLK_PERIOD_NS   = 100;
    localparam int unsigned CYCLE_TIME_MS   = 10;
    localparam int unsigned CYCLE_CLKS_DEF  = CYCLE_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned NS_PER_US       = 1000;
    localparam int unsigned UM_PER_MM       = 1000;
    localparam int unsigned PCT_FULL        = 100;

    // speed feedback limits in rpm
    localparam logic signed [15:0] SPD_MAX  = 16'sd6000;
    localparam logic signed [15:0] SPD_MIN  = -16'sd6000;

    // register byte offsets
    localparam logic [7:0] OFS_STOPDIST1 = 8'h00;
    localparam logic [7:0] OFS_STOPDIST2 = 8'h04;
    localparam logic [7:0] OFS_NOMSPD1   = 8'h08;
    localparam logic [7:0] OFS_LINSPD1   = 8'h0c;
    localparam logic [7:0] OFS_SCALE1    = 8'h10;
    localparam logic [7:0] OFS_NOMSPD2   = 8'h14;
    localparam logic [7:0] OFS_LINSPD2   = 8'h18;
    localparam logic [7:0] OFS_SCALE2    = 8'h1c;
    localparam logic [7:0] OFS_DIST1     = 8'h20;
    localparam logic [7:0] OFS_DIST2     = 8'h24;
    localparam logic [7:0] OFS_STATUS    = 8'h28;

    // reset values
    localparam logic [31:0] RST_STOPDIST = 32'h0000_0000;
    localparam logic [15:0] RST_NOMSPD   = 16'h05dc;
    localparam logic [15:0] RST_LINSPD   = 16'h03e8;
    localparam logic [7:0]  RST_SCALE    = 8'h64;

    // status register field positions
    localparam int unsigned ST_ALARM   = 0;
    localparam int unsigned ST_ENABLE  = 1;
    localparam int unsigned ST_SYNC    = 2;
    localparam int unsigned ST_CMD1    = 4;
    localparam int unsigned ST_CMD2    = 8;
    localparam int unsigned ST_BLK     = 12;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // limit switch contacts of one axis, raw normally closed levels
    typedef struct packed {
        logic fwd_stop;
        logic rev_stop;
        logic fwd_slow;
        logic rev_slow;
    } dlsi_sw_t;

    // drive commands of one axis
    typedef struct packed {
        logic fwd_run;
        logic rev_run;
        logic fwd_slow;
        logic rev_slow;
    } dlsi_cmd_t;
endpackage

// ==== verilog/dlsi_top.sv ====
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module dlsi_top #(
    parameter int unsigned CYCLE_CLKS = dlsi_pkg::CYCLE_CLKS_DEF
) (
    input  wire logic                mclk,
    input  wire logic                rst_b,
    input  wire logic                block_enable_in,
    input  wire logic                sync_select_in,
    input  wire logic                switch_alarm_inhibit,
    input  wire logic                alarm_clear_in,
    input  wire dlsi_pkg::dlsi_sw_t  axis1_switches,
    input  wire dlsi_pkg::dlsi_sw_t  axis2_switches,
    input  wire logic                axis1_fwd_request,
    input  wire logic                axis1_rev_request,
    input  wire logic                axis2_fwd_request,
    input  wire logic                axis2_rev_request,
    input  wire logic                axis1_fwd_clear_b,
    input  wire logic                axis1_rev_clear_b,
    input  wire logic                axis2_fwd_clear_b,
    input  wire logic                axis2_rev_clear_b,
    input  wire logic signed [15:0]  axis1_speed_feedback,
    input  wire logic signed [15:0]  axis2_speed_feedback,
    output logic                     axis1_fwd_run_out,
    output logic                     axis1_rev_run_out,
    output logic                     axis1_fwd_slow_out,
    output logic                     axis1_rev_slow_out,
    output logic                     axis2_fwd_run_out,
    output logic                     axis2_rev_run_out,
    output logic                     axis2_fwd_slow_out,
    output logic                     axis2_rev_slow_out,
    output logic                     alarm_out,
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready
);
    import dlsi_pkg::*;

    localparam int unsigned NSYNC    = 20;
    localparam int unsigned CYCLE_US = CYCLE_CLKS * CLK_PERIOD_NS / NS_PER_US;

    logic [1:0]       rst_sync_q;
    logic             rst_n;
    logic [NSYNC-1:0] meta_q, sync_q;
    logic [31:0]      cyc_cnt_q;
    logic             tick;
    logic             en, sync_mode, inhibit, clr_in, clr_prev_q, clr_rise;
    dlsi_sw_t         sw [2];
    logic [1:0]       req_fwd, req_rev, col_fwd, col_rev;
    logic [1:0]       r_fstop, r_rstop, r_fslow, r_rslow;
    logic [1:0]       c_fstop, c_rstop, c_fslow, c_rslow;
    logic [31:0]      stopdist_q [2];
    logic [15:0]      nomspd_q [2], linspd_q [2];
    logic [7:0]       scale_q [2];
    logic [31:0]      sd_eff [2];
    logic [31:0]      acc_q [2];
    logic [1:0]       blk_fwd_q, blk_rev_q, dblk_fwd, dblk_rev;
    logic signed [15:0] spd [2];
    dlsi_cmd_t        cmd_q [2], cmd_d [2];
    logic             alarm_q, alarm_cause;

    // reset release through two flops
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) rst_sync_q <= 2'h0;
        else        rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // two-flop synchronisers for the control, switch, request and clear pin levels
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= {block_enable_in, sync_select_in, switch_alarm_inhibit, alarm_clear_in,
                       axis1_switches, axis2_switches,
                       axis2_fwd_request, axis1_fwd_request, axis2_rev_request, // axis1 at index 0
                       axis1_rev_request, axis2_fwd_clear_b, axis1_fwd_clear_b,
                       axis2_rev_clear_b, axis1_rev_clear_b};
            sync_q <= meta_q;
        end
    end
    assign {en, sync_mode, inhibit, clr_in, sw[0], sw[1]} = sync_q[NSYNC-1:8];
    assign {req_fwd, req_rev} = sync_q[7:4];
    assign col_fwd = ~sync_q[3:2];              // sensor contact opens on approach
    assign col_rev = ~sync_q[1:0];

    // controller cycle divider
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)    cyc_cnt_q <= 32'h0;
        else if (tick) cyc_cnt_q <= 32'h0;
        else           cyc_cnt_q <= cyc_cnt_q + 32'h1;
    end
    assign tick = (cyc_cnt_q == CYCLE_CLKS - 1);

    // reached decode and axis combining
    always_comb begin
        for (int a = 0; a < 2; a++) begin
            r_fstop[a] = ~sw[a].fwd_stop;
            r_rstop[a] = ~sw[a].rev_stop;
            r_fslow[a] = ~sw[a].fwd_slow;
            r_rslow[a] = ~sw[a].rev_slow;
            spd[a] = (a == 0) ? axis1_speed_feedback : axis2_speed_feedback;
        end
        for (int a = 0; a < 2; a++) begin
            c_fstop[a] = sync_mode ? |r_fstop : r_fstop[a];
            c_rstop[a] = sync_mode ? |r_rstop : r_rstop[a];
            c_fslow[a] = sync_mode ? |r_fslow : r_fslow[a];
            c_rslow[a] = sync_mode ? |r_rslow : r_rslow[a];
            dblk_fwd[a] = sync_mode ? |blk_fwd_q : blk_fwd_q[a];
            dblk_rev[a] = sync_mode ? |blk_rev_q : blk_rev_q[a];
        end
    end

    // effective stop distance, smaller of both in sync mode
    always_comb begin
        for (int a = 0; a < 2; a++) begin
            if (sync_mode && stopdist_q[0] < stopdist_q[1]) sd_eff[a] = stopdist_q[0];
            else if (sync_mode)                              sd_eff[a] = stopdist_q[1];
            else                                             sd_eff[a] = stopdist_q[a];
        end
    end

    // distance in um for one cycle at the given speed
    function automatic logic [31:0] dist_incr(input logic signed [15:0] s,
                                              input logic [7:0] sc,
                                              input logic [15:0] lin,
                                              input logic [15:0] nom);
        logic signed [15:0] c;
        logic [63:0]        num, den;
        c = (s > SPD_MAX) ? SPD_MAX : (s < SPD_MIN) ? SPD_MIN : s;
        if (c < 0) c = -c;
        num = 64'(sc) * 64'(lin) * 64'(c) * 64'(CYCLE_US);
        den = 64'(nom) * 64'(PCT_FULL) * 64'(UM_PER_MM);
        dist_incr = (nom == 16'h0) ? 32'h0 : 32'(num / den);
    endfunction

    // stop on distance integrators and direction latches
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q     <= '{default: 32'h0};
            blk_fwd_q <= 2'h0;
            blk_rev_q <= 2'h0;
        end else if (tick) begin
            for (int a = 0; a < 2; a++) begin
                if (!en || sd_eff[a] == 32'h0 || !(c_fslow[a] || c_rslow[a])) begin
                    acc_q[a]     <= 32'h0;
                    blk_fwd_q[a] <= 1'b0;
                    blk_rev_q[a] <= 1'b0;
                end else begin
                    if ((c_fslow[a] && spd[a] > 0) || (c_rslow[a] && spd[a] < 0))
                        acc_q[a] <= acc_q[a] + dist_incr(spd[a], scale_q[a], linspd_q[a],
                                                         nomspd_q[a]);
                    if (c_fslow[a] && acc_q[a] > sd_eff[a] * UM_PER_MM)
                        blk_fwd_q[a] <= 1'b1;
                    if (c_rslow[a] && acc_q[a] > sd_eff[a] * UM_PER_MM)
                        blk_rev_q[a] <= 1'b1;
                end
            end
        end
    end

    // next commands from requests and limits
    always_comb begin
        for (int a = 0; a < 2; a++) begin
            cmd_d[a].fwd_run  = en && req_fwd[a] && !c_fstop[a] && !col_fwd[a]
                                && !dblk_fwd[a];
            cmd_d[a].rev_run  = en && req_rev[a] && !c_rstop[a] && !col_rev[a]
                                && !dblk_rev[a];
            cmd_d[a].fwd_slow = en && c_fslow[a];
            cmd_d[a].rev_slow = en && c_rslow[a];
        end
    end

    // outputs update once per controller cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)    cmd_q <= '{default: '0};
        else if (tick) cmd_q <= cmd_d;
    end
    assign {axis1_fwd_run_out, axis1_rev_run_out, axis1_fwd_slow_out, axis1_rev_slow_out} = cmd_q[0];
    assign {axis2_fwd_run_out, axis2_rev_run_out, axis2_fwd_slow_out, axis2_rev_slow_out} = cmd_q[1];

    // plausibility: stop reached before slow-down, or both stops reached
    always_comb begin
        alarm_cause = 1'b0;
        for (int a = 0; a < 2; a++)
            alarm_cause |= (r_fstop[a] && !r_fslow[a]) || (r_rstop[a] && !r_rslow[a])
                           || (r_fstop[a] && r_rstop[a]);
        alarm_cause &= en && !inhibit;
    end
    assign clr_rise = clr_in && !clr_prev_q;

    // sticky alarm, a present cause wins over the clear edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_q    <= 1'b0;
            clr_prev_q <= 1'b0;
        end else begin
            clr_prev_q <= clr_in;
            if (alarm_cause)   alarm_q <= 1'b1;
            else if (clr_rise) alarm_q <= 1'b0;
        end
    end
    assign alarm_out = alarm_q;

    // axi4-lite write channel: address and data taken together
    logic       wr_go, wr_ok;
    logic [7:0] rd_a;
    assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign wr_ok = s_axi_awaddr inside {OFS_STOPDIST1, OFS_STOPDIST2, OFS_NOMSPD1, OFS_LINSPD1,
                                        OFS_SCALE1, OFS_NOMSPD2, OFS_LINSPD2, OFS_SCALE2};

    // byte lane merge
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] st);
        for (int b = 0; b < 4; b++)
            old[b*8 +: 8] = st[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
        merge = old;
    endfunction

    // parameter registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stopdist_q <= '{default: RST_STOPDIST};
            nomspd_q   <= '{default: RST_NOMSPD};
            linspd_q   <= '{default: RST_LINSPD};
            scale_q    <= '{default: RST_SCALE};
        end else if (wr_go) begin
            unique case (s_axi_awaddr)
                OFS_STOPDIST1: stopdist_q[0] <= merge(stopdist_q[0], s_axi_wdata, s_axi_wstrb);
                OFS_STOPDIST2: stopdist_q[1] <= merge(stopdist_q[1], s_axi_wdata, s_axi_wstrb);
                OFS_NOMSPD1:   nomspd_q[0] <= 16'(merge({16'h0, nomspd_q[0]}, s_axi_wdata, s_axi_wstrb));
                OFS_LINSPD1:   linspd_q[0] <= 16'(merge({16'h0, linspd_q[0]}, s_axi_wdata, s_axi_wstrb));
                OFS_SCALE1:    scale_q[0]  <= 8'(merge({24'h0, scale_q[0]}, s_axi_wdata, s_axi_wstrb));
                OFS_NOMSPD2:   nomspd_q[1] <= 16'(merge({16'h0, nomspd_q[1]}, s_axi_wdata, s_axi_wstrb));
                OFS_LINSPD2:   linspd_q[1] <= 16'(merge({16'h0, linspd_q[1]}, s_axi_wdata, s_axi_wstrb));
                OFS_SCALE2:    scale_q[1]  <= 8'(merge({24'h0, scale_q[1]}, s_axi_wdata, s_axi_wstrb));
                default: ;
            endcase
        end
    end

    // write response
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read channel, one cycle to data
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_a          = s_axi_araddr;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            unique case (rd_a)
                OFS_STOPDIST1: s_axi_rdata <= stopdist_q[0];
                OFS_STOPDIST2: s_axi_rdata <= stopdist_q[1];
                OFS_NOMSPD1:   s_axi_rdata <= {16'h0, nomspd_q[0]};
                OFS_LINSPD1:   s_axi_rdata <= {16'h0, linspd_q[0]};
                OFS_SCALE1:    s_axi_rdata <= {24'h0, scale_q[0]};
                OFS_NOMSPD2:   s_axi_rdata <= {16'h0, nomspd_q[1]};
                OFS_LINSPD2:   s_axi_rdata <= {16'h0, linspd_q[1]};
                OFS_SCALE2:    s_axi_rdata <= {24'h0, scale_q[1]};
                OFS_DIST1:     s_axi_rdata <= acc_q[0];
                OFS_DIST2:     s_axi_rdata <= acc_q[1];
                OFS_STATUS: begin
                    s_axi_rdata                 <= 32'h0;
                    s_axi_rdata[ST_ALARM]       <= alarm_q;
                    s_axi_rdata[ST_ENABLE]      <= en;
                    s_axi_rdata[ST_SYNC]        <= sync_mode;
                    s_axi_rdata[ST_CMD1 +: 4]   <= cmd_q[0];
                    s_axi_rdata[ST_CMD2 +: 4]   <= cmd_q[1];
                    s_axi_rdata[ST_BLK +: 4]    <= {blk_rev_q, blk_fwd_q};
                end
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_cycle_start;
        tick ##1 !tick;
    endsequence

    a_cycle_spacing: assert property (s_cycle_start |-> !tick [*2])
        else $error("controller cycle tick too frequent");
    a_disabled_quiet: assert property (tick && !en |=> cmd_q[0] == '0 && cmd_q[1] == '0)
        else $error("outputs active while disabled");
    a_fwd_stop_drop: assert property (tick && c_fstop[0] |=> !axis1_fwd_run_out)
        else $error("forward run despite stop switch");
    a_rev_stop_drop: assert property (tick && c_rstop[1] |=> !axis2_rev_run_out)
        else $error("reverse run despite stop switch");
    a_fwd_slow_set: assert property (tick && en && r_fslow[0] |=> axis1_fwd_slow_out)
        else $error("forward slow not raised");
    a_rev_slow_set: assert property (tick && en && r_rslow[1] |=> axis2_rev_slow_out)
        else $error("reverse slow not raised");
    a_request_pass: assert property (tick && en && req_fwd[1] && !c_fstop[1] && !col_fwd[1]
                                     && !dblk_fwd[1] |=> axis2_fwd_run_out)
        else $error("forward request not passed");
    a_sync_shared: assert property (tick && en && sync_mode && r_rslow[0] |=>
                                    axis1_rev_slow_out && axis2_rev_slow_out)
        else $error("sync slow not on both drives");
    a_min_distance: assert property (sync_mode |-> sd_eff[0] == sd_eff[1] &&
                                     sd_eff[0] <= stopdist_q[0] && sd_eff[0] <= stopdist_q[1])
        else $error("sync stop distance not minimum");
    a_zero_no_acc: assert property (tick && sd_eff[0] == 32'h0 |=> acc_q[0] == 32'h0)
        else $error("distance accumulates while disabled");
    a_dist_block: assert property (tick && blk_rev_q[0] |=> !axis1_rev_run_out)
        else $error("run after stop on distance");
    a_collision_dir: assert property (tick && col_fwd[0] |=> !axis1_fwd_run_out)
        else $error("approach allowed with collision sensed");
    a_inhibit_quiet: assert property (inhibit && !alarm_q |=> !alarm_q)
        else $error("alarm raised while inhibited");
    a_clear_edge: assert property (clr_rise && !alarm_cause |=> !alarm_q)
        else $error("alarm not cleared on edge");
endmodule

// ==== testbench/dlsi_drive_model.sv ====
`timescale 1ns/1ps
module dlsi_drive_model (
    input  wire logic                mclk,
    input  wire dlsi_pkg::dlsi_cmd_t cmd,
    output logic signed [15:0]       speed
);
    import dlsi_pkg::*;
    initial speed = 16'sh0;
    // drive answers its run command a clock later, slow speed when forced slow
    always @(posedge mclk) begin
        if (cmd.fwd_run) begin
            speed <= cmd.fwd_slow ? 16'sh0258 : SPD_MAX;
        end else if (cmd.rev_run) begin
            speed <= cmd.rev_slow ? -16'sh0258 : SPD_MIN;
        end else begin
            speed <= 16'sh0;
        end
    end
endmodule

// ==== testbench/dlsi_top_tb.sv ====
`timescale 1ns/1ps
module dlsi_top_tb;
    import dlsi_pkg::*;
    logic mclk = 0, rst_b = 0, en = 1, sy = 0, inh = 1, clr = 0;
    dlsi_sw_t sw1 = 4'hf, sw2 = 4'hf;
    logic [3:0] rq = 4'h0, cb = 4'hf, ws = 4'h0;
    dlsi_cmd_t c1, c2;
    logic signed [15:0] sp1, sp2;
    logic al, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, awr, wrd, bv, arr, rv;
    logic [7:0] aw = 8'h0, ar = 8'h0;
    logic [31:0] wd = 32'h0, rdat, d;
    logic [1:0] br, rr, r;
    int n_mismatch = 0, n_tests = 0, seed = 55, cyc = 0;
    always #50 mclk = ~mclk;
    dlsi_top #(.CYCLE_CLKS(20)) dut (.mclk(mclk), .rst_b(rst_b), .block_enable_in(en),
        .sync_select_in(sy), .switch_alarm_inhibit(inh), .alarm_clear_in(clr),
        .axis1_switches(sw1), .axis2_switches(sw2), .axis1_fwd_request(rq[3]),
        .axis1_rev_request(rq[2]), .axis2_fwd_request(rq[1]), .axis2_rev_request(rq[0]),
        .axis1_fwd_clear_b(cb[3]), .axis1_rev_clear_b(cb[2]), .axis2_fwd_clear_b(cb[1]),
        .axis2_rev_clear_b(cb[0]), .axis1_speed_feedback(sp1), .axis2_speed_feedback(sp2),
        .axis1_fwd_run_out(c1[3]), .axis1_rev_run_out(c1[2]), .axis1_fwd_slow_out(c1[1]),
        .axis1_rev_slow_out(c1[0]), .axis2_fwd_run_out(c2[3]), .axis2_rev_run_out(c2[2]),
        .axis2_fwd_slow_out(c2[1]), .axis2_rev_slow_out(c2[0]), .alarm_out(al),
        .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ar), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rre));
    dlsi_drive_model drv1 (.mclk(mclk), .cmd(c1), .speed(sp1));
    dlsi_drive_model drv2 (.mclk(mclk), .cmd(c2), .speed(sp2));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // one register access, request held until taken, answer waited for
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        if (wr) begin
            aw  <= a;
            wd  <= v;
            ws  <= 4'hf;
            awv <= 1'b1;
            wv  <= 1'b1;
            bre <= 1'b1;
            do @(posedge mclk); while (!(awr && wrd));
            awv <= 1'b0;
            wv  <= 1'b0;
            do @(posedge mclk); while (!bv);
            r = br;
            bre <= 1'b0;
        end else begin
            ar  <= a;
            arv <= 1'b1;
            rre <= 1'b1;
            do @(posedge mclk); while (!arr);
            arv <= 1'b0;
            do @(posedge mclk); while (!rv);
            r = rr;
            d = rdat;
            rre <= 1'b0;
        end
    endtask
    // expected {run, slow} of one direction, zero distance stop
    function automatic logic [1:0] ex(input logic q, st, sl, st2, sl2, cl);
        return {q & st & cl & (st2 | !sy), !sl | (sy & !sl2)} & {2{en}};
    endfunction
    task automatic ack(input dlsi_cmd_t c, input dlsi_sw_t s, o, input logic [1:0] q, cl);
        chk({c.fwd_run, c.fwd_slow},
            ex(q[1], s.fwd_stop, s.fwd_slow, o.fwd_stop, o.fwd_slow, cl[1]));
        chk({c.rev_run, c.rev_slow},
            ex(q[0], s.rev_stop, s.rev_slow, o.rev_stop, o.rev_slow, cl[0]));
    endtask
    // hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial begin
        tick(3);
        rst_b <= 1'b1;
        tick(3);
        chk(c1, 4'h0);
        bus(0, OFS_NOMSPD1, 32'h0);
        chk(d, 32'(RST_NOMSPD));
        bus(0, OFS_SCALE1, 32'h0);
        chk(d, 32'(RST_SCALE));
        bus(0, 8'h30, 32'h0);
        chk({r, d}, {RESP_SLVERR, 32'h0});
        bus(1, OFS_STATUS, 32'h1);
        chk(r, RESP_SLVERR);
        // random requests and switches, async then sync then async again; sensors random only when async
        for (int i = 0; i < 24; i++) begin
            sy  <= i[3];
            en  <= (i % 7 != 3);
            rq  <= 4'($random(seed));
            sw1 <= 4'($random(seed));
            sw2 <= 4'($random(seed));
            cb  <= i[3] ? 4'hf : 4'($random(seed));
            tick(60);
            ack(c1, sw1, sw2, rq[3:2], cb[3:2]);
            ack(c2, sw2, sw1, rq[1:0], cb[1:0]);
            chk(al, 1'b0);
        end
        sy  <= 1'b0;
        en  <= 1'b1;
        rq  <= 4'h0;
        cb  <= 4'hf;
        sw2 <= 4'hf;
        sw1 <= 4'hf;
        tick(10);
        inh <= 1'b0;
        sw1 <= 4'h7;
        tick(10);
        chk(al, 1'b1);
        clr <= 1'b1;
        tick(10);
        chk(al, 1'b1);
        clr <= 1'b0;
        sw1 <= 4'hf;
        tick(10);
        chk(al, 1'b1);
        clr <= 1'b1;
        tick(10);
        chk(al, 1'b0);
        bus(1, OFS_NOMSPD1, 32'h1);
        bus(1, OFS_LINSPD1, 32'hc350);
        bus(1, OFS_STOPDIST1, 32'h1);
        chk(r, RESP_OKAY);
        rq  <= 4'h8;
        sw1 <= 4'hd;
        tick(200);
        chk({c1.fwd_run, c1.rev_run}, 2'h0);
        bus(0, OFS_DIST1, 32'h0);
        chk(d > 32'h3e8, 1'b1);
        bus(1, OFS_STOPDIST1, 32'h0);
        tick(60);
        chk(c1.fwd_run, 1'b1);
        give_verdict();
    end
endmodule
